/* File: hdl/dcs_pkg.sv */
// Shared constants and types for driver configuration and status readback
package dcs_pkg;

    // ------------------------------------------------------------
    // Serial frame
    // ------------------------------------------------------------
    localparam logic [4:0] FRAME_LEN = 5'h14;
    localparam logic [4:0] FRAME_LAST = 5'h13;
    localparam logic [2:0] ADDR_DRV_CONFIG = 3'h7;
    localparam logic [2:0] ADDR_CHOP_CONFIG = 3'h4;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [19:0] DRV_CONFIG_RESET = 20'h00000;
    localparam logic [3:0] SLOW_DECAY_RESET = 4'h0;
    localparam logic [19:0] STATUS_RESET = 20'h00000;
    localparam int STANDSTILL_CYCLES = 1048576;
    localparam logic [7:0] OPEN_LOAD_CLEAR_LEVEL = 8'h0F;
    localparam logic [1:0] SHORT_LIMIT = 2'h3;
    localparam logic [2:0] STRENGTH_MIN = 3'h1;
    localparam logic [1:0] UNUSED_ZERO = 2'h0;
    localparam logic [1:0] UNUSED_ONE = 2'h3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RD_MICROSTEP_POSITION = 2'b00,
        RD_STALL = 2'b01,
        RD_STALL_SCALE = 2'b10,
        RD_DIAG = 2'b11
    } dcs_readback_select_t;

    typedef struct packed {
        logic [2:0] addr;
        logic test_mode;
        logic [1:0] high_side_slope_code;
        logic [1:0] low_side_slope_code;
        logic slope_code_top_bit;
        logic ground_short_protect_off;
        logic [1:0] short_detect_delay;
        logic step_interface_disable;
        logic sense_range_select;
        dcs_readback_select_t readback_select;
        logic overtemp_sensitivity;
        logic short_sensitivity;
        logic passive_decay_enable;
        logic supply_short_protect_on;
    } dcs_drv_cfg_t;

    typedef struct packed {
        logic step;
        logic driver_disable_input;
        logic supply_low_flag;
        logic temp_detector_high;
        logic temp_detector_mid_high;
        logic temp_detector_mid;
        logic temp_detector_low;
        logic overtemp_warning_flag;
        logic coil_a_ground_short;
        logic coil_a_supply_short;
        logic coil_b_ground_short;
        logic coil_b_supply_short;
    } dcs_pin_t;

    typedef struct packed {
        logic ground_protect_en;
        logic supply_protect_en;
        logic clock_failsafe_en;
        logic uv_low_limit;
        logic sense_low_range;
        logic short_sens_high;
        logic damping_en;
        logic step_if_off;
        logic [1:0] short_detect_delay;
        logic overtemp_sensitivity;
    } dcs_ctrl_t;

endpackage

/* File: hdl/dcs_sync.sv */
// Two-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
`default_nettype none
module dcs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_in;
            sync_q <= meta_q;
        end
    end

    assign q_out = sync_q;
endmodule
`default_nettype wire

/* File: hdl/dcs_spi_link.sv */
// Serial link end: frame shifter on the link clock
`timescale 1ns/1ps
`default_nettype none
module dcs_spi_link import dcs_pkg::*; (
    input wire logic spi_clk_in,
    input wire logic resetn_in,
    input wire logic spi_csn_in,
    input wire logic spi_mosi_in,
    input wire logic [19:0] status_in,
    output logic spi_miso_out,
    output logic spi_miso_oe_out,
    output logic [19:0] word_out,
    output logic word_tgl_out
);
    logic frame_rstn;
    logic [4:0] cnt_q;
    logic [18:0] rx_q;
    logic [19:0] tx_q;

    // Frame logic is cleared by the select itself, no edge needed
    assign frame_rstn = resetn_in & ~spi_csn_in;

    always_ff @(posedge spi_clk_in or negedge frame_rstn) begin
        if (!frame_rstn) begin
            cnt_q <= 5'h00;
            rx_q <= '0;
            tx_q <= '0;
        end else if (cnt_q != FRAME_LEN) begin
            cnt_q <= cnt_q + 5'h01;
            rx_q <= {rx_q[17:0], spi_mosi_in};
            if (cnt_q == 5'h00) begin
                tx_q <= {status_in[18:0], 1'b0}; // RULE_21
            end else begin
                tx_q <= {tx_q[18:0], 1'b0};
            end
        end
    end

    // Completed word is held until the next full frame
    always_ff @(posedge spi_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            word_out <= '0;
            word_tgl_out <= 1'b0;
        end else if (!spi_csn_in && cnt_q == FRAME_LAST) begin
            word_out <= {rx_q, spi_mosi_in};
            word_tgl_out <= ~word_tgl_out;
        end
    end

    assign spi_miso_out = (cnt_q == 5'h00) ? status_in[19] : tx_q[19]; // RULE_10
    assign spi_miso_oe_out = ~spi_csn_in;
endmodule
`default_nettype wire

/* File: hdl/dcs_core.sv */
// Driver configuration register and status readback, top level
// Function
// [RULE_01] Ground short protection on when its disable bit is 0, off when 1.
// [RULE_02] Step interface disable bit set makes step input ignored.
// [RULE_03] Sense range bit: 0 high full-scale voltage, 1 low.
// [RULE_04] Readback select picks position, stall, stall plus scale, or diagnostics.
// [RULE_05] Short sensitivity bit: 0 low, 1 high sensitivity.
// [RULE_06] Passive decay bit enables damping and lowers undervoltage limit.
// [RULE_07] Supply short bit enables supply short, overcurrent and clock failsafe.
// [RULE_08] High-side codes 1,2,4,5,6 add one strength at overtemperature warning.
// [RULE_09] Low-side codes 0 and 1 give strength 1, others their value.
// [RULE_10] Every serial write gets a 20-bit status word back.
// [RULE_11] Format 00: bits 19:10 microstep position, bits 9:8 zero.
// [RULE_12] Format 01 full stall value; format 10 stall high bits plus scale.
// [RULE_13] Format 11: supply low, disable input, shorts, temperatures, bits 9:8 one.
// [RULE_14] Bit 7 set after 2^20 cycles without an active step edge.
// [RULE_15] Open-load flags set when a polarity period had no chopper event.
// [RULE_16] Open-load flag clears only above one sixteenth of full current.
// [RULE_17] Per-coil short counter; at three all bridges switch off.
// [RULE_18] Short shutdown holds until disable input or zero slow decay time.
// [RULE_19] Bit 2 shows warning threshold, bit 1 sticky overtemperature shutdown.
// [RULE_20] Bit 0 and stall pin high when stall threshold reached.
// [RULE_21] Status word is frozen for the whole serial frame.
`timescale 1ns/1ps
`default_nettype none
module dcs_core import dcs_pkg::*; #(
    parameter int STANDSTILL_LIMIT = STANDSTILL_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic spi_clk_in,
    input wire logic spi_csn_in,
    input wire logic spi_mosi_in,
    output logic spi_miso_out,
    output logic spi_miso_oe_out,
    input wire dcs_pin_t pins_in,
    input wire logic [9:0] microstep_position_in,
    input wire logic [9:0] stall_value_in,
    input wire logic [4:0] load_current_scale_in,
    input wire logic stall_reached_in,
    input wire logic [1:0] chopper_event_in,
    input wire logic [1:0] coil_polarity_in,
    input wire logic [7:0] coil_a_current_in,
    input wire logic [7:0] coil_b_current_in,
    output dcs_ctrl_t ctrl_out,
    output logic [2:0] hs_strength_out,
    output logic [2:0] ls_strength_out,
    output logic step_pulse_out,
    output logic [1:0] chopper_suspend_out,
    output logic bridges_off_out,
    output logic stall_indicator_pin_out
);
    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [1:0] short_next(input logic [1:0] cnt, input logic inc,
                                               input logic dec);
        logic [1:0] res;
        res = cnt;
        if (inc && !dec && cnt != SHORT_LIMIT) begin
            res = cnt + 2'h1;
        end else if (dec && !inc && cnt != 2'h0) begin
            res = cnt - 2'h1;
        end
        return res;
    endfunction

    function automatic logic [2:0] hs_strength(input logic [2:0] code, input logic warn);
        logic [2:0] res;
        logic tc;
        res = (code == 3'h0) ? STRENGTH_MIN : code;
        tc = (code == 3'h1) || (code == 3'h2) || (code == 3'h4) || (code == 3'h5)
            || (code == 3'h6);
        if (tc && warn) begin
            res = res + 3'h1;
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // Link and crossings
    // ------------------------------------------------------------
    logic [19:0] word_w;
    logic word_tgl_w;
    logic [19:0] shadow_q;
    dcs_pin_t pins_s;
    logic tgl_s;
    logic busy_s;

    dcs_spi_link u_link (
        .spi_clk_in(spi_clk_in),
        .resetn_in(resetn_in),
        .spi_csn_in(spi_csn_in),
        .spi_mosi_in(spi_mosi_in),
        .status_in(shadow_q),
        .spi_miso_out(spi_miso_out),
        .spi_miso_oe_out(spi_miso_oe_out),
        .word_out(word_w),
        .word_tgl_out(word_tgl_w)
    );

    dcs_sync #(.WIDTH(14)) u_sync (
        .clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .d_in({pins_in, word_tgl_w, ~spi_csn_in}),
        .q_out({pins_s, tgl_s, busy_s})
    );

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    dcs_drv_cfg_t cfg_q;
    logic [3:0] slow_decay_time_q;
    logic tgl_seen_q;
    logic wr_evt;
    dcs_drv_cfg_t wr_word;

    assign wr_evt = tgl_s ^ tgl_seen_q;
    assign wr_word = dcs_drv_cfg_t'(word_w);

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tgl_seen_q <= 1'b0;
            cfg_q <= dcs_drv_cfg_t'(DRV_CONFIG_RESET);
            slow_decay_time_q <= SLOW_DECAY_RESET;
        end else begin
            tgl_seen_q <= tgl_s;
            if (wr_evt && wr_word.addr == ADDR_DRV_CONFIG) begin
                cfg_q <= wr_word;
            end
            if (wr_evt && wr_word.addr == ADDR_CHOP_CONFIG) begin
                slow_decay_time_q <= word_w[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_out <= '0;
            hs_strength_out <= STRENGTH_MIN;
            ls_strength_out <= STRENGTH_MIN;
        end else begin
            ctrl_out.ground_protect_en <= ~cfg_q.ground_short_protect_off; // RULE_01
            ctrl_out.step_if_off <= cfg_q.step_interface_disable; // RULE_02
            ctrl_out.sense_low_range <= cfg_q.sense_range_select; // RULE_03
            ctrl_out.short_sens_high <= cfg_q.short_sensitivity; // RULE_05
            ctrl_out.damping_en <= cfg_q.passive_decay_enable; // RULE_06
            ctrl_out.uv_low_limit <= cfg_q.passive_decay_enable; // RULE_06
            ctrl_out.supply_protect_en <= cfg_q.supply_short_protect_on; // RULE_07
            ctrl_out.clock_failsafe_en <= cfg_q.supply_short_protect_on; // RULE_07
            ctrl_out.short_detect_delay <= cfg_q.short_detect_delay;
            ctrl_out.overtemp_sensitivity <= cfg_q.overtemp_sensitivity;
            hs_strength_out <= hs_strength({cfg_q.slope_code_top_bit,
                cfg_q.high_side_slope_code}, pins_s.overtemp_warning_flag); // RULE_08
            if ({cfg_q.slope_code_top_bit, cfg_q.low_side_slope_code} <= 3'h1) begin
                ls_strength_out <= STRENGTH_MIN; // RULE_09
            end else begin
                ls_strength_out <= {cfg_q.slope_code_top_bit, cfg_q.low_side_slope_code};
            end
        end
    end

    // ------------------------------------------------------------
    // Step edges and standstill
    // ------------------------------------------------------------
    dcs_pin_t pins_prev_q;
    logic [20:0] ss_cnt_q;
    logic standstill;

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pins_prev_q <= '0;
            step_pulse_out <= 1'b0;
        end else begin
            pins_prev_q <= pins_s;
            step_pulse_out <= pins_s.step & ~pins_prev_q.step
                & ~cfg_q.step_interface_disable; // RULE_02
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ss_cnt_q <= 21'h000000;
        end else if (step_pulse_out) begin
            ss_cnt_q <= 21'h000000;
        end else if (ss_cnt_q != 21'(STANDSTILL_LIMIT)) begin
            ss_cnt_q <= ss_cnt_q + 21'h000001; // RULE_14
        end
    end

    assign standstill = (ss_cnt_q == 21'(STANDSTILL_LIMIT));

    // ------------------------------------------------------------
    // Short protection per coil
    // ------------------------------------------------------------
    logic [1:0] gnd_evt;
    logic [1:0] sup_evt;
    logic [1:0] short_evt;
    logic [1:0] pol_prev_q;
    logic [1:0] pol_chg;
    logic [1:0] sc_q [2];
    logic [1:0] shut_q;
    logic [1:0] s2g_q;
    logic [1:0] s2vs_q;
    logic clear_shut;

    assign gnd_evt = {pins_s.coil_b_ground_short & ~pins_prev_q.coil_b_ground_short,
        pins_s.coil_a_ground_short & ~pins_prev_q.coil_a_ground_short}
        & {2{~cfg_q.ground_short_protect_off}}; // RULE_01
    assign sup_evt = {pins_s.coil_b_supply_short & ~pins_prev_q.coil_b_supply_short,
        pins_s.coil_a_supply_short & ~pins_prev_q.coil_a_supply_short}
        & {2{cfg_q.supply_short_protect_on}}; // RULE_07
    assign short_evt = gnd_evt | sup_evt;
    assign pol_chg = coil_polarity_in ^ pol_prev_q;
    assign clear_shut = pins_s.driver_disable_input | (slow_decay_time_q == 4'h0); // RULE_18

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pol_prev_q <= 2'h0;
            sc_q[0] <= 2'h0;
            sc_q[1] <= 2'h0;
            shut_q <= 2'h0;
            s2g_q <= 2'h0;
            s2vs_q <= 2'h0;
            chopper_suspend_out <= 2'h0;
        end else begin
            pol_prev_q <= coil_polarity_in;
            chopper_suspend_out <= short_evt; // RULE_17
            s2g_q <= gnd_evt | (s2g_q & ~{2{clear_shut}});
            s2vs_q <= sup_evt | (s2vs_q & ~{2{clear_shut}});
            for (int c = 0; c < 2; c++) begin
                if (clear_shut) begin
                    sc_q[c] <= 2'h0; // RULE_18
                    shut_q[c] <= 1'b0;
                end else if (!shut_q[c]) begin
                    sc_q[c] <= short_next(sc_q[c], short_evt[c], pol_chg[c]); // RULE_17
                    shut_q[c] <= (short_next(sc_q[c], short_evt[c], pol_chg[c])
                        == SHORT_LIMIT);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Open load, temperature and stall
    // ------------------------------------------------------------
    logic [1:0] chop_seen_q;
    logic [1:0] ol_q;
    logic [7:0] coil_cur [2];
    logic ot_flag_q;
    logic ot_trip;

    assign coil_cur[0] = coil_a_current_in;
    assign coil_cur[1] = coil_b_current_in;
    assign ot_trip = cfg_q.overtemp_sensitivity ? pins_s.temp_detector_mid_high
        : pins_s.temp_detector_high;

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            chop_seen_q <= 2'h0;
            ol_q <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (pol_chg[c]) begin
                    chop_seen_q[c] <= chopper_event_in[c];
                    if (!chop_seen_q[c] && !chopper_event_in[c]) begin
                        ol_q[c] <= 1'b1; // RULE_15
                    end else if (coil_cur[c] > OPEN_LOAD_CLEAR_LEVEL) begin
                        ol_q[c] <= 1'b0; // RULE_16
                    end
                end else if (chopper_event_in[c]) begin
                    chop_seen_q[c] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ot_flag_q <= 1'b0;
            stall_indicator_pin_out <= 1'b0;
        end else begin
            ot_flag_q <= ot_trip | (ot_flag_q & ~pins_s.driver_disable_input); // RULE_19
            stall_indicator_pin_out <= stall_reached_in; // RULE_20
        end
    end

    assign bridges_off_out = shut_q[0] | shut_q[1] | ot_flag_q; // RULE_17

    // ------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------
    logic [19:0] status_d;

    always_comb begin
        case (cfg_q.readback_select) // RULE_04
            RD_MICROSTEP_POSITION: status_d[19:8] = {microstep_position_in, UNUSED_ZERO}; // RULE_11
            RD_STALL: status_d[19:8] = {stall_value_in, UNUSED_ZERO}; // RULE_12
            RD_STALL_SCALE: status_d[19:8] = {stall_value_in[9:5], load_current_scale_in,
                UNUSED_ZERO}; // RULE_12
            RD_DIAG: status_d[19:8] = {pins_s.supply_low_flag, pins_s.driver_disable_input,
                s2vs_q[1], s2g_q[1], s2vs_q[0], s2g_q[0], pins_s.temp_detector_high,
                pins_s.temp_detector_mid_high, pins_s.temp_detector_mid,
                pins_s.temp_detector_low, UNUSED_ONE}; // RULE_13
            default: status_d[19:8] = '0;
        endcase
        status_d[7:0] = {standstill, ol_q[1], ol_q[0], shut_q[1], shut_q[0],
            pins_s.overtemp_warning_flag, ot_flag_q, stall_indicator_pin_out}; // RULE_19
    end

    // Frozen while a frame runs so the link sees one stable word
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            shadow_q <= STATUS_RESET;
        end else if (!busy_s) begin
            shadow_q <= status_d; // RULE_21
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_step_ignored: // RULE_02
        assert property (@(posedge core_clk_in) disable iff (!resetn_in)
            $past(cfg_q.step_interface_disable) |-> !step_pulse_out)
        else $error("step pulse while step interface disabled");

    a_fmt_microstep_position: // RULE_11
        assert property (@(posedge core_clk_in) disable iff (!resetn_in)
            (!busy_s && cfg_q.readback_select == RD_MICROSTEP_POSITION) |=>
            shadow_q[19:8] == {$past(microstep_position_in), 2'b00})
        else $error("position format mismatch");

    a_fmt_scale: // RULE_12
        assert property (@(posedge core_clk_in) disable iff (!resetn_in)
            (!busy_s && cfg_q.readback_select == RD_STALL_SCALE) |=>
            shadow_q[14:10] == $past(load_current_scale_in))
        else $error("current scale format mismatch");

    a_fmt_diag: // RULE_13
        assert property (@(posedge core_clk_in) disable iff (!resetn_in)
            (!busy_s && cfg_q.readback_select == RD_DIAG) |=>
            shadow_q[9:8] == 2'b11 && shadow_q[18] == $past(pins_s.driver_disable_input))
        else $error("diagnostic format mismatch");

    a_frame_frozen: // RULE_21
        assert property (@(posedge core_clk_in) disable iff (!resetn_in)
            busy_s |=> $stable(shadow_q))
        else $error("status changed inside a frame");

    a_standstill_clr: // RULE_14
        assert property (@(posedge core_clk_in) disable iff (!resetn_in)
            step_pulse_out |=> !standstill ##1 !standstill)
        else $error("standstill set right after step edge");

    a_short_trip: // RULE_17
        assert property (@(posedge core_clk_in) disable iff (!resetn_in)
            (sc_q[0] == 2'h2 && short_evt[0] && !pol_chg[0] && !clear_shut) |=>
            bridges_off_out && shadow_q[3] == $past(shadow_q[3]))
        else $error("third short did not shut bridges");

    a_shut_hold: // RULE_18
        assert property (@(posedge core_clk_in) disable iff (!resetn_in)
            (shut_q[0] && !clear_shut) |=> shut_q[0])
        else $error("shutdown released without clear");

    a_shut_clear: // RULE_18
        assert property (@(posedge core_clk_in) disable iff (!resetn_in)
            clear_shut |=> shut_q == 2'h0 && sc_q[0] == 2'h0)
        else $error("shutdown not cleared");

    a_hs_comp: // RULE_08
        assert property (@(posedge core_clk_in) disable iff (!resetn_in)
            ({cfg_q.slope_code_top_bit, cfg_q.high_side_slope_code} == 3'h6
            && pins_s.overtemp_warning_flag) |=> hs_strength_out == 3'h7)
        else $error("high side strength not raised");

    a_ls_min: // RULE_09
        assert property (@(posedge core_clk_in) disable iff (!resetn_in)
            ({cfg_q.slope_code_top_bit, cfg_q.low_side_slope_code} == 3'h0)
            |=> ls_strength_out == 3'h1)
        else $error("low side strength wrong");

    a_ol_keep: // RULE_16
        assert property (@(posedge core_clk_in) disable iff (!resetn_in)
            (ol_q[0] && coil_a_current_in <= OPEN_LOAD_CLEAR_LEVEL) |=> ol_q[0])
        else $error("open load cleared at low current");

    a_stall_pin: // RULE_20
        assert property (@(posedge core_clk_in) disable iff (!resetn_in)
            stall_reached_in |=> stall_indicator_pin_out ##1 ($past(busy_s) || shadow_q[0]))
        else $error("stall not reported");
endmodule
`default_nettype wire

/* File: dv/dcs_host.sv */
// Serial host model that writes frames and collects the status answer
`timescale 1ns/1ps
`default_nettype none
module dcs_host (
    output logic spi_clk_out,
    output logic spi_csn_out,
    output logic spi_mosi_out,
    input wire logic spi_miso_in
);
    initial begin
        spi_clk_out = 1'b0;
        spi_csn_out = 1'b1;
        spi_mosi_out = 1'b0;
    end
    // Clock stands low between frames, data line shows inverse when idle
    task automatic frame(input logic [19:0] w, output logic [19:0] r);
        int i;
        spi_csn_out = 1'b0;
        #40;
        for (i = 19; i >= 0; i--) begin
            spi_mosi_out = w[i];
            #31 r[i] = spi_miso_in;
            #1 spi_clk_out = 1'b1;
            #32 spi_clk_out = 1'b0;
        end
        #32 spi_csn_out = 1'b1;
        spi_mosi_out = ~w[0];
        #200;
    endtask
endmodule
`default_nettype wire

/* File: dv/driver_config_and_status_readback_bench.sv */
// Self-checking bench for configuration and status readback
`timescale 1ns/1ps
`default_nettype none
module driver_config_and_status_readback_bench import dcs_pkg::*;;
    logic clk = 1'b0, rstn = 1'b0, stall = 1'b0;
    dcs_pin_t pins = '0;
    logic [9:0] ms = '0, sv = '0;
    logic [4:0] se = '0;
    wire logic sclk, csn, mosi, miso;
    dcs_ctrl_t ctrl;
    logic [2:0] hs, ls;
    logic pin_o;
    int fails = 0, check_count = 0;
    logic [19:0] q[$];
    logic [19:0] got;
    logic ss = 1'b1, step_prev;
    event got_ev;
    always #2.5 clk = ~clk;
    dcs_host host (.spi_clk_out(sclk), .spi_csn_out(csn), .spi_mosi_out(mosi), .spi_miso_in(miso));
    dcs_core #(.STANDSTILL_LIMIT(64)) dut (.core_clk_in(clk), .resetn_in(rstn),
        .spi_clk_in(sclk), .spi_csn_in(csn), .spi_mosi_in(mosi), .spi_miso_out(miso),
        .spi_miso_oe_out(), .pins_in(pins), .microstep_position_in(ms),
        .stall_value_in(sv), .load_current_scale_in(se), .stall_reached_in(stall),
        .chopper_event_in(2'h0), .coil_polarity_in(2'h0), .coil_a_current_in(8'h00),
        .coil_b_current_in(8'h00), .ctrl_out(ctrl), .hs_strength_out(hs),
        .ls_strength_out(ls), .step_pulse_out(), .chopper_suspend_out(),
        .bridges_off_out(), .stall_indicator_pin_out(pin_o));
    task automatic check_val(input logic [19:0] a, input logic [19:0] e);
        check_count++;
        if (a !== e) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, a, e);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    function automatic logic [2:0] hs_exp(input logic [2:0] c, input logic w);
        if (c == 3'h0) return 3'h1;
        if (c == 3'h3 || c == 3'h7) return c;
        return c + {2'h0, w};
    endfunction
    function automatic logic [19:0] st_exp(input logic [1:0] sel);
        logic [11:0] hi;
        case (sel)
            2'h0: hi = {ms, 2'h0};
            2'h1: hi = {sv, 2'h0};
            2'h2: hi = {sv[9:5], se, 2'h0};
            default: hi = {pins.supply_low_flag, pins.driver_disable_input, 8'h00, 2'h3};
        endcase
        return {hi, ss, 4'h0, pins.overtemp_warning_flag, 1'b0, stall};
    endfunction
    // Status answers compared as they arrive
    always @(got_ev) begin
        check_val(got, q.pop_front());
    end
    initial begin
        logic [19:0] cfg;
        logic [19:0] r;
        logic [2:0] lc;
        int k;
        void'($urandom(32'hC217));
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        for (k = 0; k < 8; k++) begin
            cfg = {4'hE, 16'($urandom())};
            cfg[5:4] = k[1:0];
            host.frame(cfg, r);
            check_val({9'h0, ctrl}, {9'h0, ~cfg[10], cfg[0], cfg[0], cfg[1], cfg[6], cfg[2],
                cfg[1], cfg[7], cfg[9:8], cfg[3]});
            @(negedge clk);
            step_prev = pins.step;
            {pins.step, pins.driver_disable_input, pins.supply_low_flag} = 3'($urandom());
            ss = !(pins.step && !step_prev && !cfg[7]);
            {pins.overtemp_warning_flag, stall, ms, sv, se} = 27'($urandom());
            repeat (8) @(negedge clk);
            check_val({19'h0, pin_o}, {19'h0, stall});
            lc = {cfg[11], cfg[13:12]};
            check_val({17'h0, ls}, {17'h0, (lc < 3'h2) ? 3'h1 : lc});
            check_val({17'h0, hs}, {17'h0, hs_exp({cfg[11], cfg[15:14]}, pins.overtemp_warning_flag)});
            q.push_back(st_exp(cfg[5:4]));
            host.frame(cfg, got);
            -> got_ev;
            $display("test %0d done", k);
        end
        @(negedge clk);
        tally_and_finish();
    end
    initial begin
        #100000;
        fails++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
